//--- sfsp_regs.vh
`ifndef SFSP_REGS_VH
`define SFSP_REGS_VH

`define SFSP_OP_WR_EN 8'h06
`define SFSP_OP_WR_DIS 8'h04
`define SFSP_OP_ID 8'h9F
`define SFSP_OP_STAT_RD 8'h05
`define SFSP_OP_STAT_WR 8'h01
`define SFSP_OP_PROG 8'h02
`define SFSP_OP_SECT 8'hD8
`define SFSP_OP_BULK 8'hC7

`define SFSP_ST_BUSY 0
`define SFSP_ST_LATCH 1
`define SFSP_ST_BP_LO 2
`define SFSP_ST_BP_HI 3
`define SFSP_ST_DISABLE 7

`define SFSP_RST_DISABLE 1'b0
`define SFSP_RST_BP 2'b00

`define SFSP_CLK_MHZ 20
`define SFSP_T_W_US 5000
`define SFSP_T_PROG_US 2000
`define SFSP_T_SECT_US 500000
`define SFSP_T_BULK_US 1000000
`define SFSP_TIMER_W 25

`endif

//--- sfsp_timer.v
`default_nettype none
module sfsp_timer #(
    parameter CW = 25
) (
    input wire mclk,
    input wire rst,
    input wire start,
    input wire [CW-1:0] load,
    output reg busy
);
    reg [CW-1:0] count;

    // countdown of one self-timed cycle
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            count <= {CW{1'b0}};
            busy <= 1'b0;
        end else if (start) begin
            count <= load;
            busy <= 1'b1;
        end else if (busy) begin
            if (count <= {{(CW-1){1'b0}}, 1'b1}) begin
                busy <= 1'b0;
                count <= {CW{1'b0}};
            end else begin
                count <= count - {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule // sfsp_timer
`default_nettype wire

//--- sfsp_core.v
`include "sfsp_regs.vh"
`default_nettype none
module sfsp_core #(
    parameter [7:0] MAKER_CODE = 8'hA5,
    parameter [7:0] TYPE_CODE = 8'h3C,
    parameter [7:0] SIZE_CODE = 8'h5A,
    parameter integer W_CYC = `SFSP_T_W_US * `SFSP_CLK_MHZ,
    parameter integer PROG_CYC = `SFSP_T_PROG_US * `SFSP_CLK_MHZ,
    parameter integer SECT_CYC = `SFSP_T_SECT_US * `SFSP_CLK_MHZ,
    parameter integer BULK_CYC = `SFSP_T_BULK_US * `SFSP_CLK_MHZ
) (
    input wire mclk,
    input wire rst,
    input wire ce_n,
    input wire sclk,
    input wire si,
    input wire wp_n,
    output reg so,
    output reg so_oe,
    output reg [7:0] status_out,
    output reg hardware_protected_mode,
    output reg software_protected_mode
);
    // identity codes above are arbitrary values

    localparam CW = `SFSP_TIMER_W;
    localparam [CW-1:0] W_LOAD = W_CYC[CW-1:0];
    localparam [CW-1:0] PROG_LOAD = PROG_CYC[CW-1:0];
    localparam [CW-1:0] SECT_LOAD = SECT_CYC[CW-1:0];
    localparam [CW-1:0] BULK_LOAD = BULK_CYC[CW-1:0];
    localparam [23:0] ID_WORD = {MAKER_CODE, TYPE_CODE, SIZE_CODE};

    ////////////////////////////////////////////////////////////////////////
    // state

    reg sclk_q;
    reg ce_q;
    reg [6:0] shift_in;
    reg [2:0] bit_cnt;
    reg [2:0] byte_cnt;
    reg [7:0] opcode;
    reg [7:0] data_byte;
    reg sector_hi;
    reg [4:0] out_idx;
    reg write_enable_latch;
    reg status_write_disable;
    reg [1:0] bp;
    reg out_active;
    reg id_blocked;
    reg tmr_start;
    reg [CW-1:0] tmr_load;
    wire busy;

    wire sclk_rise = sclk & ~sclk_q & ~ce_n;
    wire sclk_fall = ~sclk & sclk_q & ~ce_n;
    wire ce_rise = ce_n & ~ce_q;
    wire [7:0] new_byte = {shift_in, si};
    wire [7:0] status_byte;
    wire hw_prot;
    wire on_byte;
    wire area_prot;

    assign status_byte = {status_write_disable, 3'b000, bp, write_enable_latch, busy};
    assign hw_prot = status_write_disable & ~wp_n;
    assign on_byte = (bit_cnt == 3'd0);
    assign area_prot = (bp == 2'b00) ? 1'b0 :
                       (bp == 2'b01) ? sector_hi : 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // cycle timer

    sfsp_timer #(
        .CW(CW)
    ) u_timer (
        .mclk(mclk),
        .rst(rst),
        .start(tmr_start),
        .load(tmr_load),
        .busy(busy)
    );

    ////////////////////////////////////////////////////////////////////////
    // serial input and frame tracking

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            sclk_q <= 1'b0;
            ce_q <= 1'b1;
            shift_in <= 7'h00;
            bit_cnt <= 3'd0;
            byte_cnt <= 3'd0;
            opcode <= 8'h00;
            data_byte <= 8'h00;
            sector_hi <= 1'b0;
        end else begin
            sclk_q <= sclk;
            ce_q <= ce_n;
            if (ce_n) begin
                bit_cnt <= 3'd0;
                byte_cnt <= 3'd0;
            end else if (sclk_rise) begin
                shift_in <= new_byte[6:0];
                bit_cnt <= bit_cnt + 3'd1;
                if (bit_cnt == 3'd7) begin
                    if (byte_cnt != 3'd7) begin
                        byte_cnt <= byte_cnt + 3'd1;
                    end
                    if (byte_cnt == 3'd0) begin
                        opcode <= new_byte;
                    end
                    if (byte_cnt == 3'd1) begin
                        data_byte <= new_byte;
                    end
                    if (byte_cnt == 3'd2) begin
                        sector_hi <= new_byte[7];
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial output

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            so <= 1'b0;
            so_oe <= 1'b0;
            out_idx <= 5'd0;
            out_active <= 1'b0;
            id_blocked <= 1'b0;
        end else if (ce_n) begin
            so_oe <= 1'b0;
            so <= 1'b0;
            out_idx <= 5'd0;
            out_active <= 1'b0;
            id_blocked <= 1'b0;
        end else if (sclk_fall && byte_cnt != 3'd0) begin
            if (opcode == `SFSP_OP_STAT_RD) begin
                so_oe <= 1'b1;
                so <= status_byte[3'd7 - out_idx[2:0]];
                out_idx <= {2'b00, out_idx[2:0] + 3'd1};
            end else if (opcode == `SFSP_OP_ID) begin
                if (!out_active && busy) begin
                    id_blocked <= 1'b1;
                end
                out_active <= 1'b1;
                if (!(id_blocked || (!out_active && busy))) begin
                    so_oe <= 1'b1;
                    if (out_idx < 5'd24) begin
                        so <= ID_WORD[5'd23 - out_idx];
                        out_idx <= out_idx + 5'd1;
                    end else begin
                        so <= 1'b0;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // execution at the end of a frame

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            write_enable_latch <= 1'b0;
            status_write_disable <= `SFSP_RST_DISABLE;
            bp <= `SFSP_RST_BP;
            tmr_start <= 1'b0;
            tmr_load <= {CW{1'b0}};
        end else begin
            tmr_start <= 1'b0;
            if (ce_rise && !busy && on_byte) begin
                case (opcode)
                    `SFSP_OP_WR_EN: begin
                        if (byte_cnt == 3'd1) begin
                            write_enable_latch <= 1'b1;
                        end
                    end
                    `SFSP_OP_WR_DIS: begin
                        if (byte_cnt == 3'd1) begin
                            write_enable_latch <= 1'b0;
                        end
                    end
                    `SFSP_OP_STAT_WR: begin
                        if (byte_cnt == 3'd2 && write_enable_latch && !hw_prot) begin
                            status_write_disable <= data_byte[`SFSP_ST_DISABLE];
                            bp <= data_byte[`SFSP_ST_BP_HI:`SFSP_ST_BP_LO];
                            write_enable_latch <= 1'b0;
                            tmr_load <= W_LOAD;
                            tmr_start <= 1'b1;
                        end
                    end
                    `SFSP_OP_PROG: begin
                        if (byte_cnt >= 3'd5 && write_enable_latch && !area_prot) begin
                            write_enable_latch <= 1'b0;
                            tmr_load <= PROG_LOAD;
                            tmr_start <= 1'b1;
                        end
                    end
                    `SFSP_OP_SECT: begin
                        if (byte_cnt == 3'd4 && write_enable_latch && !area_prot) begin
                            write_enable_latch <= 1'b0;
                            tmr_load <= SECT_LOAD;
                            tmr_start <= 1'b1;
                        end
                    end
                    `SFSP_OP_BULK: begin
                        if (byte_cnt == 3'd1 && write_enable_latch && bp == 2'b00) begin
                            write_enable_latch <= 1'b0;
                            tmr_load <= BULK_LOAD;
                            tmr_start <= 1'b1;
                        end
                    end
                    default: begin
                        write_enable_latch <= write_enable_latch;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered status outputs

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            status_out <= 8'h00;
            hardware_protected_mode <= 1'b0;
            software_protected_mode <= 1'b0;
        end else begin
            status_out <= status_byte;
            hardware_protected_mode <= hw_prot;
            software_protected_mode <= ~hw_prot;
        end
    end
endmodule // sfsp_core
`default_nettype wire

//--- sfsp_monitor.sv
`default_nettype none
module sfsp_monitor (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce_n,
    input wire logic sclk,
    input wire logic si,
    input wire logic wp_n,
    input wire logic so,
    input wire logic so_oe,
    input wire logic [7:0] status_out,
    input wire logic hardware_protected_mode,
    input wire logic software_protected_mode
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    wire logic [2:0] nv = {status_out[7], status_out[3:2]};
    ////////////////////////////////////////////////////////////////
    zero_bits_a: assert property (status_out[6:4] == 3'h0)
        else $error("status bits 6 to 4 not zero");
    pin_high_a: assert property ($past(wp_n) |-> !hardware_protected_mode)
        else $error("protected mode with pin high");
    mode_pair_a: assert property (!$past(rst)
        |-> software_protected_mode != hardware_protected_mode)
        else $error("mode outputs not complementary");
    idle_out_a: assert property (ce_n [*3] |-> !so_oe)
        else $error("output driven while deselected");
    out_edge_a: assert property (!$stable(so) && so_oe && $past(so_oe)
        |-> ($past(sclk, 2) && !$past(sclk)) || ($past(sclk, 3) && !$past(sclk, 2)))
        else $error("output changed without clock fall");
    busy_latch_a: assert property ($rose(status_out[0]) |-> ##[0:2] !status_out[1])
        else $error("latch not cleared by cycle");
    needs_latch_a: assert property ($rose(status_out[0]) |-> $past(status_out[1], 3))
        else $error("cycle started without latch");
    busy_hold_a: assert property ($rose(status_out[0]) |-> status_out[0] [*8])
        else $error("busy flag dropped early");
    nv_write_a: assert property (!$stable(nv) |-> ##[0:1] status_out[0])
        else $error("protect bits changed without cycle");
    hw_lock_a: assert property (hardware_protected_mode [*3] |=> $stable(nv))
        else $error("protect bits changed when locked");
endmodule // sfsp_monitor
bind sfsp_core sfsp_monitor i_sfsp_monitor (.mclk, .rst, .ce_n, .sclk, .si, .wp_n, .so,
    .so_oe, .status_out, .hardware_protected_mode, .software_protected_mode);
`default_nettype wire

//--- sfsp_host.sv
`default_nettype none
module sfsp_host (
    input wire logic mclk,
    input wire logic so,
    input wire logic so_oe,
    output logic ce_n,
    output logic sclk,
    output logic si
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        ce_n = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // n bits from tx msb down; rx keeps the latest samples, released line reads 1
    task automatic frame(input logic [31:0] tx, input int n, output logic [31:0] rx);
        rx = '0;
        ce_n = 1'b0;
        tick(2);
        for (int i = 0; i < n; i++) begin
            sclk = 1'b0;
            si = tx[31-i];
            tick(2);
            rx = {rx[30:0], so_oe ? so : 1'b1};
            sclk = 1'b1;
            tick(2);
        end
        sclk = 1'b0;
        tick(2);
        ce_n = 1'b1;
        si = ~si;
        tick(3);
    endtask
endmodule // sfsp_host
`default_nettype wire

//--- testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic wp_n = 1'b1;
    wire ce_n, sclk, si, so, so_oe, hw_mode, sw_mode;
    wire [7:0] st;
    logic [31:0] rx;
    logic [7:0] d;
    int num_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    int seed = 54;
    int lat = 0;
    int bp = 0;
    int dis = 0;
    always #25 mclk = ~mclk;
    sfsp_core #(.W_CYC(20), .PROG_CYC(20), .SECT_CYC(20), .BULK_CYC(200)) i_sfsp_core (
        .mclk, .rst, .ce_n, .sclk, .si, .wp_n, .so, .so_oe, .status_out(st),
        .hardware_protected_mode(hw_mode), .software_protected_mode(sw_mode));
    sfsp_host i_sfsp_host (.mclk, .so, .so_oe, .ce_n, .sclk, .si);
    ////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic op(input logic [7:0] c, input int n);
        i_sfsp_host.frame({c, 24'h0}, n, rx);
    endtask
    task automatic read_status(input int busy);
        op(8'h05, 24);
        check("status", rx[15:0], {2{dis[0], 3'h0, bp[1:0], lat[0], busy[0]}});
    endtask
    task automatic swr(input logic [7:0] v, input int n, input logic en);
        int exe;
        op(en ? 8'h06 : 8'h04, 8);
        lat = en;
        exe = lat && n == 16 && !(dis && !wp_n);
        i_sfsp_host.frame({8'h01, v, 16'h0}, n, rx);
        check("busy", st[0], exe);
        if (exe) begin
            lat = 0;
            dis = v[7];
            bp = v[3:2];
        end
        repeat (25) @(negedge mclk);
        check("hw mode", hw_mode, dis && !wp_n);
        read_status(0);
    endtask
    task automatic stop_test;
        $display("compares %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 30000) begin
            num_errors++;
            stop_test();
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        repeat (2) @(negedge mclk);
        read_status(0);
        op(8'h9F, 32);
        check("ident", rx[23:0], 24'hA53C5A);
        op(8'h06, 8);
        lat = 1;
        read_status(0);
        op(8'h04, 9);
        read_status(0);
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            wp_n = d[5];
            swr(d, 16 + i % 2, i != 2);
        end
        wp_n = 1'b1;
        for (int k = 0; k < 2; k++) begin
            swr({4'h0, k[0], k[0], 2'h0}, 16, 1'b1);
            op(8'h06, 8);
            op(8'hC7, 8);
            lat = k;
            check("erase", st[0], !k);
            read_status(!k);
            op(8'h9F, 16);
            check("ident busy", rx[7:0], k ? 8'hA5 : 8'hFF);
            repeat (210) @(negedge mclk);
        end
        stop_test();
    end
endmodule // testbench
`default_nettype wire
